// ==== src/pwg_pkg.sv ====
// Constants, command codes and field positions of the key and write-guard block.
// Assumes a PMBus word-level command port in front of it; one 20 MHz clock.
package pwg_pkg;
	localparam logic [7:0] CMD_FAULT_INJECTION = 8'hf1;
	localparam logic [7:0] CMD_UNLOCK_KEY = 8'hfa;
	localparam logic [7:0] CMD_FINE_WRITE_GUARD = 8'hfb;
	localparam logic [7:0] CMD_PLATFORM_IDENTIFIER_WORD = 8'hfc;
	localparam logic [15:0] KEY_ZERO = 16'h0000;
	localparam logic [15:0] KEY_STAT_UNLOCKED = 16'h0000;
	localparam logic [15:0] KEY_STAT_LOCKED0 = 16'h000f;
	localparam logic [15:0] KEY_STAT_LOCKED1 = 16'h001f;
	localparam logic [15:0] KEY_STAT_LOCKED2 = 16'h002f;
	localparam logic [15:0] KEY_STAT_LOCKED3 = 16'h00ff;
	localparam logic [1:0] KEY_MISS_LIMIT = 2'h3;
	localparam logic [15:0] FAULT_INJECTION_RESET = 16'h0000;
	localparam int GUARD_SAVE = 0;
	localparam int GUARD_KEY = 1;
	localparam int GUARD_BOOT_SETTINGS = 2;
	localparam int GUARD_STD_WP = 14;
	localparam int GUARD_SELF_LOCK = 15;
	localparam int GROUP_COUNT = 16;
	localparam int INJ_WARN_PERSIST = 7;
	localparam int INJ_FAULT_PERSIST = 15;
	// Injection bits that drive detector outputs, in fault_o / warn_o order
	localparam logic [15:0] INJ_FAULT_MASK = 16'h5f00;
	localparam logic [15:0] INJ_WARN_MASK = 16'h001b;
	// Faults that may act with conversion off: input lockout (11), output OV (8)
	localparam logic [15:0] INJ_FAULT_ANYTIME = 16'h0900;
	// Identifier readback; the value is arbitrary
	localparam logic [31:0] PLATFORM_ID_DEFAULT = 32'h0000_1234;
	// Command port status codes
	localparam logic [1:0] ACK_OK = 2'h0;
	localparam logic [1:0] ACK_PROTECTED = 2'h1;
	localparam logic [1:0] ACK_UNSUPPORTED = 2'h2;
	typedef enum logic [1:0] {
		PWG_KEY_OPEN = 2'b00,
		PWG_KEY_LOCKED = 2'b01,
		PWG_KEY_BARRED = 2'b10
	} pwg_key_state_t;
endpackage

// ==== src/pwg_key_unit.sv ====
// Unlock key state machine: active key, mismatch count and lockout.
// Assumes boot key and boot load strobe come from the nonvolatile loader on the same clock.
`timescale 1ns/10ps
`default_nettype none
module pwg_key_unit (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic boot_load_i,
	input wire logic [15:0] boot_key_i,
	input wire logic key_write_i,
	input wire logic [15:0] key_data_i,
	output logic key_locked_o,
	output logic [15:0] key_status_o,
	output logic [15:0] active_key_o
);
	import pwg_pkg::*;
	typedef struct packed {
		pwg_key_state_t st;
		logic [15:0] key;
		logic [1:0] miss;
		logic [15:0] status;
	} pwg_key_reg_t;
	pwg_key_reg_t r;
	pwg_key_reg_t next_r;
	always_comb begin
		next_r = r;
		if (boot_load_i) begin
			next_r.key = boot_key_i;
			next_r.miss = 2'h0;
			next_r.st = (boot_key_i == KEY_ZERO) ? PWG_KEY_OPEN : PWG_KEY_LOCKED;
		end else if (key_write_i) begin
			case (r.st)
				PWG_KEY_OPEN: begin
					next_r.key = key_data_i;
				end
				PWG_KEY_LOCKED: begin
					if (key_data_i == r.key) begin
						next_r.st = PWG_KEY_OPEN;
						next_r.miss = 2'h0;
					end else begin
						next_r.miss = r.miss + 2'h1;
						if (r.miss + 2'h1 == KEY_MISS_LIMIT) begin
							next_r.st = PWG_KEY_BARRED;
						end
					end
				end
				PWG_KEY_BARRED: begin
					next_r.st = PWG_KEY_BARRED;
				end
				default: begin
					next_r.st = PWG_KEY_BARRED;
				end
			endcase
		end
		case (next_r.st)
			PWG_KEY_OPEN: next_r.status = KEY_STAT_UNLOCKED;
			PWG_KEY_LOCKED: begin
				case (next_r.miss)
					2'h0: next_r.status = KEY_STAT_LOCKED0;
					2'h1: next_r.status = KEY_STAT_LOCKED1;
					2'h2: next_r.status = KEY_STAT_LOCKED2;
					default: next_r.status = KEY_STAT_LOCKED3;
				endcase
			end
			default: next_r.status = KEY_STAT_LOCKED3;
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			r <= '{st: PWG_KEY_OPEN, key: KEY_ZERO, miss: 2'h0, status: KEY_STAT_UNLOCKED};
		end else begin
			r <= next_r;
		end
	end
	assign key_locked_o = (r.st != PWG_KEY_OPEN);
	assign key_status_o = r.status;
	assign active_key_o = r.key;

	AST_KEY_BAR_STICKS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.st == PWG_KEY_BARRED && !boot_load_i) |=> (r.st == PWG_KEY_BARRED && r.status == KEY_STAT_LOCKED3))
		else $error("key lockout left without boot load");
	AST_KEY_MATCH_OPENS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.st == PWG_KEY_LOCKED && key_write_i && !boot_load_i && key_data_i == r.key)
		|=> (r.st == PWG_KEY_OPEN && r.miss == 2'h0))
		else $error("matching key did not unlock");
	AST_KEY_STATUS_NOT_KEY: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.st == PWG_KEY_LOCKED) |-> (r.status == {10'h0, r.miss, 4'hf}))
		else $error("key status mismatches miss count");
endmodule
`default_nettype wire

// ==== src/pwg_inject_unit.sv ====
// Fault injection word and simulated detector outputs with persistence control.
// Assumes fault_response_i pulses once per completed fault response of the power stage.
`timescale 1ns/10ps
`default_nettype none
module pwg_inject_unit (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic write_i,
	input wire logic [15:0] data_i,
	input wire logic conv_enable_i,
	input wire logic fault_response_i,
	output logic [15:0] word_o,
	output logic [15:0] fault_o,
	output logic [15:0] warn_o
);
	import pwg_pkg::*;
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] fault;
		logic [15:0] warn;
	} pwg_inj_reg_t;
	pwg_inj_reg_t r;
	pwg_inj_reg_t next_r;
	always_comb begin
		next_r = r;
		if (write_i) begin
			next_r.word = data_i;
			next_r.fault = r.fault | (data_i & INJ_FAULT_MASK);
			next_r.warn = r.warn | (data_i & INJ_WARN_MASK);
			if (data_i[INJ_FAULT_PERSIST]) begin
				next_r.fault = data_i & INJ_FAULT_MASK;
			end
			if (data_i[INJ_WARN_PERSIST]) begin
				next_r.warn = data_i & INJ_WARN_MASK;
			end
		end else if (fault_response_i) begin
			if (!r.word[INJ_FAULT_PERSIST]) begin
				next_r.fault = 16'h0000;
			end
			if (!r.word[INJ_WARN_PERSIST]) begin
				next_r.warn = 16'h0000;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			r <= '{word: FAULT_INJECTION_RESET, fault: 16'h0000, warn: 16'h0000};
		end else begin
			r <= next_r;
		end
	end
	assign word_o = r.word;
	assign fault_o = conv_enable_i ? r.fault : (r.fault & INJ_FAULT_ANYTIME);
	assign warn_o = conv_enable_i ? r.warn : 16'h0000;

	AST_INJ_UNUSED_QUIET: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(fault_o[13] == 1'b0 && warn_o[6:5] == 2'b00 && warn_o[2] == 1'b0))
		else $error("unused injection bit raised a condition");
	AST_INJ_WARN_AUTOCLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(fault_response_i && !write_i && !r.word[INJ_WARN_PERSIST]) |=> (r.warn == 16'h0000))
		else $error("warning not cleared after fault response");
	AST_INJ_FAULT_OFF_GATE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(!conv_enable_i) |-> ((fault_o & ~INJ_FAULT_ANYTIME) == 16'h0000))
		else $error("gated fault acted with conversion off");
endmodule
`default_nettype wire

// ==== src/pwg_write_guard.sv ====
// Top of the command-level guard: key, fine write guard, injection, identifier.
// Assumes a PMBus front end decodes word transactions into cmd, strobes and data on core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module pwg_write_guard (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic boot_load_i,
	input wire logic restore_i,
	input wire logic [15:0] boot_key_i,
	input wire logic [15:0] boot_guard_i,
	input wire logic [7:0] cmd_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] group_sel_i,
	input wire logic std_wp_block_i,
	input wire logic conv_enable_i,
	input wire logic fault_response_i,
	output logic [15:0] rdata_o,
	output logic done_o,
	output logic [1:0] ack_o,
	output logic [15:0] group_wr_o,
	output logic save_allowed_o,
	output logic [15:0] fault_o,
	output logic [15:0] warn_o
);
	import pwg_pkg::*;
	typedef struct packed {
		logic [15:0] guard;
		logic save_locked;
		logic [15:0] rdata;
		logic done;
		logic [1:0] ack;
		logic [15:0] group_wr;
		logic save_allowed;
		logic [15:0] fault;
		logic [15:0] warn;
	} pwg_top_reg_t;
	pwg_top_reg_t r;
	pwg_top_reg_t next_r;
	logic key_locked;
	logic [15:0] key_status;
	logic [15:0] active_key;
	logic key_wr_ok;
	logic guard_wr_ok;
	logic inj_wr_ok;
	logic [15:0] inj_word;
	logic [15:0] inj_fault;
	logic [15:0] inj_warn;
	logic [15:0] group_open;

	// Per-group write permission from the guard word; group 0 from the save lock copied at boot load or restore
	genvar g;
	generate
		for (g = 0; g < GROUP_COUNT; g = g + 1) begin : gen_group
			if (g == GUARD_SELF_LOCK) begin : gen_self
				assign group_open[g] = !r.guard[g] && !key_locked;
			end else if (g == GUARD_STD_WP) begin : gen_wp
				assign group_open[g] = !r.guard[g];
			end else if (g == GUARD_SAVE) begin : gen_save
				assign group_open[g] = !r.save_locked && !std_wp_block_i && !key_locked;
			end else begin : gen_std
				assign group_open[g] = !r.guard[g] && !std_wp_block_i;
			end
		end
	endgenerate

	assign key_wr_ok = wr_i && (cmd_i == CMD_UNLOCK_KEY) && !r.guard[GUARD_SELF_LOCK]
		&& !r.guard[GUARD_KEY] && !std_wp_block_i;
	assign guard_wr_ok = wr_i && (cmd_i == CMD_FINE_WRITE_GUARD) && group_open[GUARD_SELF_LOCK];
	assign inj_wr_ok = wr_i && (cmd_i == CMD_FAULT_INJECTION) && !r.guard[9] && !std_wp_block_i;

	pwg_key_unit u_key (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.boot_load_i(boot_load_i),
		.boot_key_i(boot_key_i),
		.key_write_i(key_wr_ok),
		.key_data_i(wdata_i),
		.key_locked_o(key_locked),
		.key_status_o(key_status),
		.active_key_o(active_key)
	);

	pwg_inject_unit u_inject (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.write_i(inj_wr_ok),
		.data_i(wdata_i),
		.conv_enable_i(conv_enable_i),
		.fault_response_i(fault_response_i),
		.word_o(inj_word),
		.fault_o(inj_fault),
		.warn_o(inj_warn)
	);

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.ack = ACK_OK;
		next_r.group_wr = group_open;
		next_r.save_allowed = group_open[GUARD_SAVE];
		next_r.fault = inj_fault;
		next_r.warn = inj_warn;
		if (boot_load_i) begin
			next_r.guard = boot_guard_i;
			next_r.save_locked = boot_guard_i[GUARD_SAVE];
		end else if (restore_i) begin
			next_r.save_locked = r.guard[GUARD_SAVE];
		end else if (guard_wr_ok) begin
			next_r.guard = wdata_i;
		end
		if (wr_i) begin
			next_r.done = 1'b1;
			case (cmd_i)
				CMD_UNLOCK_KEY: next_r.ack = key_wr_ok ? ACK_OK : ACK_PROTECTED;
				CMD_FINE_WRITE_GUARD: next_r.ack = guard_wr_ok ? ACK_OK : ACK_PROTECTED;
				CMD_FAULT_INJECTION: next_r.ack = inj_wr_ok ? ACK_OK : ACK_PROTECTED;
				CMD_PLATFORM_IDENTIFIER_WORD: next_r.ack = ACK_OK;
				default: next_r.ack = (|(group_sel_i & ~group_open)) ? ACK_PROTECTED : ACK_OK;
			endcase
		end else if (rd_i) begin
			next_r.done = 1'b1;
			case (cmd_i)
				CMD_UNLOCK_KEY: next_r.rdata = key_status;
				CMD_FINE_WRITE_GUARD: next_r.rdata = r.guard;
				CMD_FAULT_INJECTION: next_r.rdata = inj_word;
				CMD_PLATFORM_IDENTIFIER_WORD: next_r.rdata = PLATFORM_ID_DEFAULT[15:0];
				default: begin
					next_r.rdata = 16'h0000;
					next_r.ack = ACK_UNSUPPORTED;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_o = r.rdata;
	assign done_o = r.done;
	assign ack_o = r.ack;
	assign group_wr_o = r.group_wr;
	assign save_allowed_o = r.save_allowed;
	assign fault_o = r.fault;
	assign warn_o = r.warn;

	AST_ID_WRITE_ACCEPTED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(wr_i && cmd_i == CMD_PLATFORM_IDENTIFIER_WORD) |=> (done_o && ack_o == ACK_OK))
		else $error("identifier write flagged");
	AST_GUARD_LOCKED_BY_KEY: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(key_locked && wr_i && cmd_i == CMD_FINE_WRITE_GUARD && !boot_load_i) |=> (r.guard == $past(r.guard)))
		else $error("guard word changed while key locked");
	AST_SELF_LOCK: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.guard[GUARD_SELF_LOCK] && wr_i && cmd_i == CMD_FINE_WRITE_GUARD) |=> (ack_o == ACK_PROTECTED))
		else $error("self-locked guard word accepted a write");
	AST_KEY_GUARDED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.guard[GUARD_KEY] && wr_i && cmd_i == CMD_UNLOCK_KEY) |=> (ack_o == ACK_PROTECTED))
		else $error("guarded key accepted a write");
	AST_STD_WP_GUARD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(r.guard[GUARD_STD_WP]) |=> (!group_wr_o[GUARD_STD_WP]))
		else $error("standard write-protect writable under guard");
	AST_SAVE_KEY: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(!key_locked && !r.save_locked && !std_wp_block_i) |=> save_allowed_o)
		else $error("save refused with key zero");
	AST_KEY_OPEN_LOADS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(!key_locked && key_wr_ok && !boot_load_i) |=> (active_key == $past(wdata_i)))
		else $error("open key write did not load the key");
endmodule
`default_nettype wire

// ==== tb/pwg_host_model.sv ====
// Host side model: issues word writes and reads to the guard block.
// Assumes the block answers each request with a one-cycle done pulse.
`timescale 1ns/10ps
`default_nettype none
module pwg_host_model (
	input wire logic core_clk_i,
	input wire logic done_i,
	input wire logic [1:0] ack_i,
	input wire logic [15:0] rdata_i,
	output logic [7:0] cmd_o,
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] wdata_o
);
	initial begin
		cmd_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 16'h0000;
	end
	// One word transfer, entered just after an edge; no answer gives unknown ack
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [1:0] a,
		output logic [15:0] q);
		int n;
		cmd_o = c;
		wr_o = w;
		rd_o = !w;
		wdata_o = d;
		@(posedge core_clk_i);
		#1;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = ~d;
		n = 0;
		while (done_i !== 1'b1 && n < 4) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		a = (n == 4) ? 2'bxx : ack_i;
		q = rdata_i;
		// Idle cycle between requests
		@(posedge core_clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ==== tb/pwg_write_guard_test.sv ====
// Self-checking bench of the key and write-guard block.
// Assumes the host model drives the command port; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module pwg_write_guard_test;
	import pwg_pkg::*;
	logic clk = 1'b0, rst = 1'b1, bload = 1'b0, rest = 1'b0, wr, rd, done, sv, stdwp = 1'b0, conv = 1'b1, fresp = 1'b0;
	logic [15:0] bkey = 16'h0000, bguard = 16'h0000, wdata, gsel = 16'h0001, rdata, gwr, flt, wrn, k, g, d, eo;
	logic [7:0] cmd;
	logic [1:0] ack;
	int error_cnt = 0, tests_run = 0, seed, i;
	always #25 clk = ~clk;
	pwg_write_guard pwg_write_guard_i (.core_clk_i(clk), .reset_i(rst), .boot_load_i(bload), .restore_i(rest),
		.boot_key_i(bkey), .boot_guard_i(bguard), .cmd_i(cmd), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
		.group_sel_i(gsel), .std_wp_block_i(stdwp), .conv_enable_i(conv), .fault_response_i(fresp),
		.rdata_o(rdata), .done_o(done), .ack_o(ack), .group_wr_o(gwr), .save_allowed_o(sv), .fault_o(flt),
		.warn_o(wrn));
	pwg_host_model pwg_host_model_i (.core_clk_i(clk), .done_i(done), .ack_i(ack), .rdata_i(rdata),
		.cmd_o(cmd), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Write word and check its ack
	task automatic wrw(input logic [7:0] c, input logic [15:0] dd, input logic [1:0] ea);
		logic [1:0] a;
		logic [15:0] q;
		pwg_host_model_i.xfer(1'b1, c, dd, a, q);
		chk("write ack", {14'h0, a}, {14'h0, ea});
	endtask
	task automatic rdw(input logic [7:0] c, input logic [15:0] e, input logic [1:0] ea);
		logic [1:0] a;
		logic [15:0] q;
		pwg_host_model_i.xfer(1'b0, c, 16'h0000, a, q);
		chk("read ack", {14'h0, a}, {14'h0, ea});
		chk("read data", q, e);
	endtask
	// Power-on reset then nonvolatile load
	task automatic boot(input logic [15:0] kk, input logic [15:0] gg);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		bkey = kk;
		bguard = gg;
		bload = 1'b1;
		tick(1);
		bload = 1'b0;
	endtask
	task automatic close_out();
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#(50 * 5000);
		error_cnt++;
		close_out();
	end
	initial begin
		seed = 98;
		@(posedge clk);
		#1;
		k = 16'($random(seed)) | 16'h0100;
		boot(k, 16'h0000);
		rdw(CMD_UNLOCK_KEY, KEY_STAT_LOCKED0, ACK_OK);
		wrw(CMD_FINE_WRITE_GUARD, 16'h0000, ACK_PROTECTED);
		chk("save allowed", {15'h0, sv}, 16'h0000);
		for (i = 0; i < 2; i++) begin
			wrw(CMD_UNLOCK_KEY, k ^ 16'h0001, ACK_OK);
			rdw(CMD_UNLOCK_KEY, i ? KEY_STAT_LOCKED2 : KEY_STAT_LOCKED1, ACK_OK);
		end
		wrw(CMD_UNLOCK_KEY, k, ACK_OK);
		rdw(CMD_UNLOCK_KEY, KEY_STAT_UNLOCKED, ACK_OK);
		wrw(CMD_UNLOCK_KEY, k, ACK_OK);
		tick(3);
		chk("save allowed", {15'h0, sv}, 16'h0001);
		for (i = 0; i < 4; i++) begin
			g = (16'($random(seed)) & 16'h3ffc) | (i[0] ? 16'h4000 : 16'h0000);
			stdwp = 1'b0;
			gsel = 16'h0001 << ($random(seed) & 15);
			wrw(CMD_FINE_WRITE_GUARD, g, ACK_OK);
			stdwp = i[1];
			eo = (~g & 16'h3fff & {16{!i[1]}}) | (~g & 16'h4000) | 16'h8000;
			tick(3);
			chk("group writable", gwr, eo);
			wrw(8'h01, 16'($random(seed)), (|(gsel & ~eo)) ? ACK_PROTECTED : ACK_OK);
			rdw(CMD_FINE_WRITE_GUARD, g, ACK_OK);
		end
		stdwp = 1'b0;
		wrw(CMD_FINE_WRITE_GUARD, 16'h0002, ACK_OK);
		wrw(CMD_UNLOCK_KEY, k, ACK_PROTECTED);
		wrw(CMD_FINE_WRITE_GUARD, 16'h8000, ACK_OK);
		wrw(CMD_FINE_WRITE_GUARD, 16'h0000, ACK_PROTECTED);
		wrw(CMD_UNLOCK_KEY, k, ACK_PROTECTED);
		boot(k, 16'h0000);
		for (i = 0; i < 3; i++)
			wrw(CMD_UNLOCK_KEY, ~k, ACK_OK);
		wrw(CMD_UNLOCK_KEY, k, ACK_OK);
		rdw(CMD_UNLOCK_KEY, KEY_STAT_LOCKED3, ACK_OK);
		wrw(CMD_FINE_WRITE_GUARD, 16'h0000, ACK_PROTECTED);
		boot(k, 16'h0000);
		rdw(CMD_UNLOCK_KEY, KEY_STAT_LOCKED0, ACK_OK);
		boot(16'h0000, 16'h0001);
		tick(3);
		chk("save allowed", {15'h0, sv}, 16'h0000);
		wrw(CMD_FINE_WRITE_GUARD, 16'h0000, ACK_OK);
		tick(3);
		chk("save allowed", {15'h0, sv}, 16'h0000);
		rest = 1'b1;
		tick(1);
		rest = 1'b0;
		tick(3);
		chk("save allowed", {15'h0, sv}, 16'h0001);
		wrw(CMD_PLATFORM_IDENTIFIER_WORD, 16'($random(seed)), ACK_OK);
		rdw(CMD_PLATFORM_IDENTIFIER_WORD, PLATFORM_ID_DEFAULT[15:0], ACK_OK);
		rdw(8'hf9, 16'h0000, ACK_UNSUPPORTED);
		d = 16'($random(seed)) | 16'h8080;
		wrw(CMD_FAULT_INJECTION, d, ACK_OK);
		tick(3);
		chk("fault", flt, d & INJ_FAULT_MASK);
		chk("warn", wrn, d & INJ_WARN_MASK);
		fresp = 1'b1;
		tick(1);
		fresp = 1'b0;
		conv = 1'b0;
		tick(3);
		chk("fault", flt, d & INJ_FAULT_ANYTIME);
		chk("warn", wrn, 16'h0000);
		conv = 1'b1;
		tick(3);
		chk("warn", wrn, d & INJ_WARN_MASK);
		boot(16'h0000, 16'h0000);
		d = (16'($random(seed)) & 16'h7f7f) | 16'h0101;
		wrw(CMD_FAULT_INJECTION, d, ACK_OK);
		tick(3);
		chk("fault", flt, d & INJ_FAULT_MASK);
		chk("warn", wrn, d & INJ_WARN_MASK);
		wrw(CMD_FAULT_INJECTION, 16'h0000, ACK_OK);
		tick(3);
		chk("fault", flt, d & INJ_FAULT_MASK);
		chk("warn", wrn, d & INJ_WARN_MASK);
		fresp = 1'b1;
		tick(1);
		fresp = 1'b0;
		tick(3);
		chk("fault", flt, 16'h0000);
		chk("warn", wrn, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
